//--- shared/ppj_map.svh
`ifndef PPJ_MAP_SVH
`define PPJ_MAP_SVH
`define PPJ_NP 4
`define PPJ_NC 8
`define PPJ_A_CTRL 12'h000
`define PPJ_A_MON 12'h004
`define PPJ_A_CCAT 12'h008
`define PPJ_A_THR 12'h00C
`define PPJ_A_STAT 12'h010
`define PPJ_A_IEN 12'h014
`define PPJ_A_ICLR 12'h018
`define PPJ_A_PTR_HI 8'h02
`define PPJ_A_CNT_HI 5'h02
`define PPJ_C_PDET 3'h0
`define PPJ_C_PGEN 3'h1
`define PPJ_C_NDET 3'h2
`define PPJ_C_NGEN 3'h3
`define PPJ_C_DIFF 3'h4
`define PPJ_C_DSEC 3'h5
`define PPJ_C_GSEC 3'h6
`define PPJ_C_FAR 3'h7
`define PPJ_CTRL_EN 0
`define PPJ_RST_THR 16'hFFFF
`define PPJ_PTR_MAX 10'h30E
`define PPJ_NDF_SET 4'h9
`define PPJ_I_MASK 10'h2AA
`define PPJ_D_MASK 10'h155
`define PPJ_MAJ 4'h3
`define PPJ_SEC_MS 1000
`define PPJ_CLK_KHZ 100000
`define PPJ_SEC_CYC (`PPJ_SEC_MS * `PPJ_CLK_KHZ)
`endif

//--- shared/ppj_pkg.sv
`default_nettype none
package ppj_pkg;
	typedef logic [15:0] ppj_cnt_t;
	typedef logic [9:0] ppj_ptr_t;
	typedef enum logic [1:0]
	{
		PPJ_IDLE = 2'h1,
		PPJ_DONE = 2'h2
	} ppj_bus_e;
endpackage
`default_nettype wire

//--- shared/ppj_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppj_reg_if;
	logic [11:0] addr;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        err;
	modport slv (output addr, output wr, output wdata, input rdata, input err);
	modport core (input addr, input wr, input wdata, output rdata, output err);
endinterface
`default_nettype wire

//--- logic/ppj_apb_slv.sv
`timescale 1ns/1ps
`default_nettype none
module ppj_apb_slv
(
	input  wire logic        ref_clk_in,  // clock
	input  wire logic        sys_rst_in,  // sync reset, high
	input  wire logic        psel_in,     // select
	input  wire logic        penable_in,  // access phase
	input  wire logic        pwrite_in,   // write
	input  wire logic [11:0] paddr_in,    // byte address
	input  wire logic [31:0] pwdata_in,   // write data
	output logic [31:0]      prdata_out,  // read data
	output logic             pready_out,  // transfer done
	output logic             pslverr_out, // unmapped address
	ppj_reg_if.slv           rif          // register side
);
	ppj_pkg::ppj_bus_e st_q;
	ppj_pkg::ppj_bus_e st_d;
	logic [31:0]       rd_q;
	logic [31:0]       rd_d;
	logic              rdy_q;
	logic              rdy_d;
	logic              err_q;
	logic              err_d;

	assign rif.addr = paddr_in;
	assign rif.wdata = pwdata_in;
	// write lands on the completing edge only
	assign rif.wr = psel_in & penable_in & rdy_q & pwrite_in;
	assign prdata_out = rd_q;
	assign pready_out = rdy_q;
	assign pslverr_out = err_q;

	always_comb
	begin
		st_d = st_q;
		rd_d = rd_q;
		rdy_d = 1'b0;
		err_d = 1'b0;
		case (st_q)
			ppj_pkg::PPJ_IDLE:
			begin
				if (psel_in && penable_in)
				begin
					st_d = ppj_pkg::PPJ_DONE;
					rdy_d = 1'b1;
					err_d = rif.err;
					rd_d = pwrite_in ? 32'h0000_0000 : rif.rdata;
				end
			end
			ppj_pkg::PPJ_DONE:
				st_d = ppj_pkg::PPJ_IDLE;
			default:
				st_d = ppj_pkg::PPJ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			st_q <= ppj_pkg::PPJ_IDLE;
			rd_q <= 32'h0000_0000;
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			rd_q <= rd_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
		end
	end
endmodule
`default_nettype wire

//--- logic/ppj_ptr_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppj_map.svh"
module ppj_ptr_dec
(
	input  wire logic         ref_clk_in, // clock
	input  wire logic         sys_rst_in, // sync reset, high
	input  wire logic         frame_in,   // pointer bytes valid
	input  wire logic [7:0]   h1_in,      // first pointer byte
	input  wire logic [7:0]   h2_in,      // second pointer byte
	output logic              pos_out,    // positive justification seen
	output logic              neg_out,    // negative justification seen
	output ppj_pkg::ppj_ptr_t ptr_out,    // offset to payload start
	output logic              ok_out      // offset is valid
);
	ppj_pkg::ppj_ptr_t cur_q;
	ppj_pkg::ppj_ptr_t cur_d;
	ppj_pkg::ppj_ptr_t word;
	logic              ok_q;
	logic              ok_d;
	logic              pos_q;
	logic              pos_d;
	logic              neg_q;
	logic              neg_d;
	logic              ndf;
	logic [3:0]        ni;
	logic [3:0]        nd;

	function automatic logic [3:0] ones(input ppj_pkg::ppj_ptr_t v);
		logic [3:0] n;
		n = 4'h0;
		for (int b = 0; b < 10; b++)
			n = n + {3'h0, v[b]};
		return n;
	endfunction

	assign pos_out = pos_q;
	assign neg_out = neg_q;
	assign ptr_out = cur_q;
	assign ok_out = ok_q;

	always_comb
	begin
		word = {h1_in[1:0], h2_in}; // see R6
		ndf = (h1_in[7:4] == `PPJ_NDF_SET);
		ni = ones((word ^ cur_q) & `PPJ_I_MASK);
		nd = ones((word ^ cur_q) & `PPJ_D_MASK);
		cur_d = cur_q;
		ok_d = ok_q;
		pos_d = 1'b0;
		neg_d = 1'b0;
		if (frame_in)
		begin
			// majority of inverted increment bits marks a positive step
			if (ok_q && !ndf && ni >= `PPJ_MAJ && nd < `PPJ_MAJ)
			begin
				pos_d = 1'b1;
				cur_d = (cur_q == `PPJ_PTR_MAX) ? 10'h000 : cur_q + 10'h001; // see R7
			end
			else if (ok_q && !ndf && nd >= `PPJ_MAJ && ni < `PPJ_MAJ)
			begin
				neg_d = 1'b1;
				cur_d = (cur_q == 10'h000) ? `PPJ_PTR_MAX : cur_q - 10'h001; // see R7
			end
			else
			begin
				ok_d = (word <= `PPJ_PTR_MAX); // see R7
				cur_d = ok_d ? word : cur_q;
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			cur_q <= 10'h000;
			ok_q <= 1'b0;
			pos_q <= 1'b0;
			neg_q <= 1'b0;
		end
		else
		begin
			cur_q <= cur_d;
			ok_q <= ok_d;
			pos_q <= pos_d;
			neg_q <= neg_d;
		end
	end

	property p_ptr_range;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		ok_q |-> (cur_q <= `PPJ_PTR_MAX);
	endproperty
	a_ptr_range: assert property (p_ptr_range) else $error("offset beyond range"); // see R7

	property p_ptr_load;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
		(frame_in && !ok_q && word <= `PPJ_PTR_MAX) |=> (ok_q && cur_q == $past(word));
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("offset not taken from pointer bytes"); // see R6
endmodule
`default_nettype wire

//--- logic/ppj_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppj_map.svh"
// Functional notes
// R1: count path data only on paths whose monitor enable is set.
// R2: alerts come only from paths selected for monitoring.
// R3: contiguous group members after the first cannot be enabled.
// R4: virtual group members each have their own enable.
// R5: enabled paths gather near-end and far-end data.
// R6: pointer value comes from the two pointer bytes.
// R7: pointer is a byte offset, valid from 0 to 782.
// R8: four counters: positive and negative, detected and generated.
// R9: difference is absolute value of detected versus generated totals; code takes each total as net, pos minus neg, as in R15.
// R10: detected seconds counts intervals holding any detected justification.
// R11: generated seconds counts intervals holding any generated justification.
// R12: slow payload frame rate yields a generated positive justification.
// R13: justification counters stay empty until management enables them.
// R14: generate justifications against the local clock and count each.
// R15: difference is (gen pos - gen neg) - (det pos - det neg), absolute.
// R16: one shared local timebase marks seconds for every path.
module ppj_top
#(
	parameter int unsigned SEC_CYCLES = `PPJ_SEC_CYC // clock cycles per second
)
(
	input  wire logic                     ref_clk_in,  // 100 MHz clock
	input  wire logic                     sys_rst_in,  // sync reset, high
	input  wire logic                     psel_in,     // apb select
	input  wire logic                     penable_in,  // apb access phase
	input  wire logic                     pwrite_in,   // apb write
	input  wire logic [11:0]              paddr_in,    // apb byte address
	input  wire logic [31:0]              pwdata_in,   // apb write data
	output logic [31:0]                   prdata_out,  // apb read data
	output logic                          pready_out,  // apb ready
	output logic                          pslverr_out, // apb error
	input  wire logic [`PPJ_NP-1:0]       frame_in,    // pointer bytes valid, per path
	input  wire logic [`PPJ_NP-1:0][7:0]  h1_in,       // first pointer byte, per path
	input  wire logic [`PPJ_NP-1:0][7:0]  h2_in,       // second pointer byte, per path
	input  wire logic [`PPJ_NP-1:0]       slow_in,     // payload slower than local clock
	input  wire logic [`PPJ_NP-1:0]       fast_in,     // payload faster than local clock
	input  wire logic [`PPJ_NP-1:0]       far_err_in,  // far-end error report pulse
	output logic [`PPJ_NP-1:0]            gen_pos_out, // positive justification request
	output logic [`PPJ_NP-1:0]            gen_neg_out, // negative justification request
	output logic [`PPJ_NP-1:0]            tca_out,     // threshold crossing alert level
	output logic                          irq_out      // interrupt, high
);
	ppj_reg_if rif ();
	logic                          pjc_en_q;
	logic                          pjc_en_d;
	logic [`PPJ_NP-1:0]            mon_q;
	logic [`PPJ_NP-1:0]            mon_d;
	logic [`PPJ_NP-1:0]            ccat_q;
	logic [`PPJ_NP-1:0]            ccat_d;
	ppj_pkg::ppj_cnt_t             thr_q;
	ppj_pkg::ppj_cnt_t             thr_d;
	logic [`PPJ_NP-1:0]            ien_q;
	logic [`PPJ_NP-1:0]            ien_d;
	logic [`PPJ_NP-1:0]            stat_q;
	logic [`PPJ_NP-1:0]            stat_d;
	logic [`PPJ_NP-1:0]            tca_q;
	logic [`PPJ_NP-1:0]            tca_d;
	logic [`PPJ_NP-1:0]            clr;
	logic                          irq_q;
	logic                          irq_d;
	logic [31:0]                   sec_cnt_q;
	logic [31:0]                   sec_cnt_d;
	logic                          tick_q;
	logic                          tick_d;
	logic [`PPJ_NP-1:0]            gpos_q;
	logic [`PPJ_NP-1:0]            gpos_d;
	logic [`PPJ_NP-1:0]            gneg_q;
	logic [`PPJ_NP-1:0]            gneg_d;
	logic [`PPJ_NP-1:0]            dseen_q;
	logic [`PPJ_NP-1:0]            dseen_d;
	logic [`PPJ_NP-1:0]            gseen_q;
	logic [`PPJ_NP-1:0]            gseen_d;
	ppj_pkg::ppj_cnt_t             cnt_q [`PPJ_NP][`PPJ_NC];
	ppj_pkg::ppj_cnt_t             cnt_d [`PPJ_NP][`PPJ_NC];
	logic [`PPJ_NP-1:0]            pos_det;
	logic [`PPJ_NP-1:0]            neg_det;
	logic [`PPJ_NP-1:0]            ptr_ok;
	ppj_pkg::ppj_ptr_t             ptr_val [`PPJ_NP];
	logic [`PPJ_NP-1:0]            path_on;
	logic [`PPJ_NP-1:0]            cnt_on;

	function automatic logic is_cnt(input logic [11:0] a);
		return (a[11:7] == `PPJ_A_CNT_HI) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic is_ptr(input logic [11:0] a);
		return (a[11:4] == `PPJ_A_PTR_HI) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [31:0] wd(input logic [`PPJ_NP-1:0] v);
		return {{(32-`PPJ_NP){1'b0}}, v};
	endfunction

	function automatic ppj_pkg::ppj_cnt_t inc(input ppj_pkg::ppj_cnt_t v, input logic en);
		return en ? v + 16'h0001 : v;
	endfunction

	function automatic ppj_pkg::ppj_cnt_t jdiff(input ppj_pkg::ppj_cnt_t pd, pg, nd, ng);
		logic signed [17:0] s;
		logic signed [17:0] m;
		s = ($signed({2'h0, pg}) - $signed({2'h0, ng})) - ($signed({2'h0, pd}) - $signed({2'h0, nd}));
		m = s[17] ? -s : s;
		return m[15:0];
	endfunction

	ppj_apb_slv u_apb
	(
		.ref_clk_in  (ref_clk_in),
		.sys_rst_in  (sys_rst_in),
		.psel_in     (psel_in),
		.penable_in  (penable_in),
		.pwrite_in   (pwrite_in),
		.paddr_in    (paddr_in),
		.pwdata_in   (pwdata_in),
		.prdata_out  (prdata_out),
		.pready_out  (pready_out),
		.pslverr_out (pslverr_out),
		.rif         (rif.slv)
	);

	for (genvar g = 0; g < `PPJ_NP; g++)
	begin : g_path
		ppj_ptr_dec u_dec
		(
			.ref_clk_in (ref_clk_in),
			.sys_rst_in (sys_rst_in),
			.frame_in   (frame_in[g]),
			.h1_in      (h1_in[g]),
			.h2_in      (h2_in[g]),
			.pos_out    (pos_det[g]),
			.neg_out    (neg_det[g]),
			.ptr_out    (ptr_val[g]),
			.ok_out     (ptr_ok[g])
		);
	end

	// trailing members of a contiguous group are never monitored
	assign path_on = mon_q & ~ccat_q; // see R1 see R3 see R4
	assign cnt_on = path_on & {`PPJ_NP{pjc_en_q}}; // see R13
	assign gen_pos_out = gpos_q;
	assign gen_neg_out = gneg_q;
	assign tca_out = tca_q;
	assign irq_out = irq_q;

	// configuration, alerts and interrupt
	always_comb
	begin
		pjc_en_d = pjc_en_q;
		mon_d = mon_q;
		ccat_d = ccat_q;
		thr_d = thr_q;
		ien_d = ien_q;
		clr = '0;
		if (rif.wr)
		begin
			case (rif.addr)
				`PPJ_A_CTRL: pjc_en_d = rif.wdata[`PPJ_CTRL_EN];
				`PPJ_A_MON: mon_d = rif.wdata[`PPJ_NP-1:0];
				`PPJ_A_CCAT: ccat_d = rif.wdata[`PPJ_NP-1:0];
				`PPJ_A_THR: thr_d = rif.wdata[15:0];
				`PPJ_A_IEN: ien_d = rif.wdata[`PPJ_NP-1:0];
				`PPJ_A_ICLR: clr = rif.wdata[`PPJ_NP-1:0];
				default: pjc_en_d = pjc_en_q;
			endcase
		end
		for (int i = 0; i < `PPJ_NP; i++)
			tca_d[i] = path_on[i] && (cnt_q[i][`PPJ_C_DIFF] >= thr_q); // see R2
		// a new crossing beats a clear in the same cycle
		stat_d = (stat_q & ~clr) | (tca_d & ~tca_q);
		irq_d = |(stat_q & ien_q);
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			pjc_en_q <= 1'b0;
			mon_q <= '0;
			ccat_q <= '0;
			thr_q <= `PPJ_RST_THR;
			ien_q <= '0;
			stat_q <= '0;
			tca_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			pjc_en_q <= pjc_en_d;
			mon_q <= mon_d;
			ccat_q <= ccat_d;
			thr_q <= thr_d;
			ien_q <= ien_d;
			stat_q <= stat_d;
			tca_q <= tca_d;
			irq_q <= irq_d;
		end
	end

	// shared second timebase and justification generation
	always_comb
	begin
		tick_d = (sec_cnt_q == SEC_CYCLES - 1); // see R16
		sec_cnt_d = tick_d ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
		gpos_d = frame_in & slow_in & ~fast_in; // see R12
		gneg_d = frame_in & fast_in & ~slow_in; // see R14
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			sec_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
			gpos_q <= '0;
			gneg_q <= '0;
		end
		else
		begin
			sec_cnt_q <= sec_cnt_d;
			tick_q <= tick_d;
			gpos_q <= gpos_d;
			gneg_q <= gneg_d;
		end
	end

	// per-path counters
	always_comb
	begin
		logic dhit;
		logic ghit;
		dhit = 1'b0;
		ghit = 1'b0;
		dseen_d = dseen_q;
		gseen_d = gseen_q;
		for (int i = 0; i < `PPJ_NP; i++)
		begin
			for (int c = 0; c < `PPJ_NC; c++)
				cnt_d[i][c] = cnt_q[i][c];
			cnt_d[i][`PPJ_C_PDET] = inc(cnt_q[i][`PPJ_C_PDET], cnt_on[i] & pos_det[i]); // see R8
			cnt_d[i][`PPJ_C_NDET] = inc(cnt_q[i][`PPJ_C_NDET], cnt_on[i] & neg_det[i]); // see R8
			cnt_d[i][`PPJ_C_PGEN] = inc(cnt_q[i][`PPJ_C_PGEN], cnt_on[i] & gpos_q[i]); // see R12
			cnt_d[i][`PPJ_C_NGEN] = inc(cnt_q[i][`PPJ_C_NGEN], cnt_on[i] & gneg_q[i]); // see R14
			cnt_d[i][`PPJ_C_DIFF] = jdiff(cnt_q[i][`PPJ_C_PDET], cnt_q[i][`PPJ_C_PGEN],
				cnt_q[i][`PPJ_C_NDET], cnt_q[i][`PPJ_C_NGEN]); // see R9 see R15
			// an event in the tick cycle belongs to the closing second
			dhit = dseen_q[i] | (cnt_on[i] & (pos_det[i] | neg_det[i]));
			ghit = gseen_q[i] | (cnt_on[i] & (gpos_q[i] | gneg_q[i]));
			cnt_d[i][`PPJ_C_DSEC] = inc(cnt_q[i][`PPJ_C_DSEC], tick_q & dhit); // see R10
			cnt_d[i][`PPJ_C_GSEC] = inc(cnt_q[i][`PPJ_C_GSEC], tick_q & ghit); // see R11
			dseen_d[i] = dhit & ~tick_q;
			gseen_d[i] = ghit & ~tick_q;
			cnt_d[i][`PPJ_C_FAR] = inc(cnt_q[i][`PPJ_C_FAR], path_on[i] & far_err_in[i]); // see R5
			if (!pjc_en_q)
			begin
				for (int c = 0; c < `PPJ_C_FAR; c++)
					cnt_d[i][c] = 16'h0000; // see R13
				dseen_d[i] = 1'b0;
				gseen_d[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			for (int i = 0; i < `PPJ_NP; i++)
				for (int c = 0; c < `PPJ_NC; c++)
					cnt_q[i][c] <= 16'h0000;
			dseen_q <= '0;
			gseen_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_d;
			dseen_q <= dseen_d;
			gseen_q <= gseen_d;
		end
	end

	// register read mux and address check
	always_comb
	begin
		rif.rdata = 32'h0000_0000;
		rif.err = 1'b0;
		if (is_cnt(rif.addr))
			rif.rdata = {16'h0000, cnt_q[rif.addr[6:5]][rif.addr[4:2]]};
		else if (is_ptr(rif.addr))
			rif.rdata = {21'h00000, ptr_ok[rif.addr[3:2]], ptr_val[rif.addr[3:2]]};
		else
		begin
			case (rif.addr)
				`PPJ_A_CTRL: rif.rdata = {31'h00000000, pjc_en_q};
				`PPJ_A_MON: rif.rdata = wd(mon_q);
				`PPJ_A_CCAT: rif.rdata = wd(ccat_q);
				`PPJ_A_THR: rif.rdata = {16'h0000, thr_q};
				`PPJ_A_STAT: rif.rdata = wd(stat_q);
				`PPJ_A_IEN: rif.rdata = wd(ien_q);
				`PPJ_A_ICLR: rif.rdata = 32'h0000_0000;
				default: rif.err = 1'b1;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	property p_off_hold;
		(!path_on[1] && pjc_en_q) |=> $stable(cnt_q[1][`PPJ_C_PDET]) && $stable(cnt_q[1][`PPJ_C_FAR]);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("unmonitored path counted"); // see R1

	property p_tca_gate;
		(!path_on[1] && !stat_q[1]) |=> !stat_q[1] && !tca_q[1];
	endproperty
	a_tca_gate: assert property (p_tca_gate) else $error("alert on unmonitored path"); // see R2

	property p_ccat;
		(ccat_q[1] && far_err_in[1]) |=> $stable(cnt_q[1][`PPJ_C_FAR]);
	endproperty
	a_ccat: assert property (p_ccat) else $error("contiguous member monitored"); // see R3

	property p_vcat;
		(mon_q[2] && !ccat_q[2] && ccat_q[1]) |-> path_on[2];
	endproperty
	a_vcat: assert property (p_vcat) else $error("member enable not independent"); // see R4

	property p_far;
		(path_on[0] && far_err_in[0]) |=> cnt_q[0][`PPJ_C_FAR] == $past(cnt_q[0][`PPJ_C_FAR]) + 16'h0001;
	endproperty
	a_far: assert property (p_far) else $error("far-end event lost"); // see R5

	property p_ndet;
		(cnt_on[0] && neg_det[0]) |=> cnt_q[0][`PPJ_C_NDET] == $past(cnt_q[0][`PPJ_C_NDET]) + 16'h0001;
	endproperty
	a_ndet: assert property (p_ndet) else $error("negative detection not counted"); // see R8

	property p_diff;
		pjc_en_q |=> cnt_q[0][`PPJ_C_DIFF] == jdiff($past(cnt_q[0][`PPJ_C_PDET]), $past(cnt_q[0][`PPJ_C_PGEN]),
			$past(cnt_q[0][`PPJ_C_NDET]), $past(cnt_q[0][`PPJ_C_NGEN]));
	endproperty
	a_diff: assert property (p_diff) else $error("difference wrong"); // see R15

	property p_dsec;
		(tick_q && pjc_en_q && (dseen_q[0] || (cnt_on[0] && pos_det[0])))
			|=> cnt_q[0][`PPJ_C_DSEC] == $past(cnt_q[0][`PPJ_C_DSEC]) + 16'h0001 ##1 !dseen_q[0] || !tick_q;
	endproperty
	a_dsec: assert property (p_dsec) else $error("detected second not counted"); // see R10

	property p_gsec;
		(tick_q && pjc_en_q && gseen_q[0]) |=> cnt_q[0][`PPJ_C_GSEC] == $past(cnt_q[0][`PPJ_C_GSEC]) + 16'h0001;
	endproperty
	a_gsec: assert property (p_gsec) else $error("generated second not counted"); // see R11

	property p_gpos;
		(frame_in[0] && slow_in[0] && !fast_in[0]) |=> gen_pos_out[0] && !gen_neg_out[0];
	endproperty
	a_gpos: assert property (p_gpos) else $error("no positive justification for slow payload"); // see R12

	property p_empty;
		!pjc_en_q |=> cnt_q[0][`PPJ_C_PDET] == 16'h0000 && cnt_q[0][`PPJ_C_DSEC] == 16'h0000;
	endproperty
	a_empty: assert property (p_empty) else $error("disabled counter not empty"); // see R13

	property p_gneg;
		(frame_in[2] && fast_in[2] && !slow_in[2]) ##1 cnt_on[2]
			|=> cnt_q[2][`PPJ_C_NGEN] == $past(cnt_q[2][`PPJ_C_NGEN]) + 16'h0001;
	endproperty
	a_gneg: assert property (p_gneg) else $error("generated negative not counted"); // see R14

	property p_tick;
		tick_q |-> sec_cnt_q == 32'h0000_0000 && $past(sec_cnt_q) == SEC_CYCLES - 1;
	endproperty
	a_tick: assert property (p_tick) else $error("second boundary misplaced"); // see R16

	c_pdet: cover property (cnt_on[0] && pos_det[0]);
	c_tca: cover property (stat_q[0] && irq_q);
	c_sec: cover property (tick_q && dseen_q[0]);
endmodule
`default_nettype wire

//--- dv/ppj_fram.sv
`timescale 1ns/1ps
`default_nettype none
module ppj_fram
(
	input  wire logic       ref_clk_in, // clock
	output logic [3:0]      frame_out,  // pointer bytes valid
	output logic [3:0][7:0] h1_out,     // first pointer byte
	output logic [3:0][7:0] h2_out,     // second pointer byte
	output logic [3:0]      slow_out,   // payload slow
	output logic [3:0]      fast_out    // payload fast
);
	logic [3:0][9:0] cur;
	initial
	begin
		{frame_out, h1_out, h2_out, slow_out, fast_out, cur} = '0;
	end
	// k: 0 new pointer, 1 increment, 2 decrement, 3 steady
	task automatic send(input int p, input int k, input logic [9:0] v, input logic s, input logic f);
		logic [9:0] w;
		w = (k == 0) ? v : cur[p];
		if (k == 1) w = w ^ 10'h2AA;
		if (k == 2) w = w ^ 10'h155;
		@(posedge ref_clk_in);
		frame_out[p] <= 1'b1;
		h1_out[p] <= {(k == 0) ? 4'h9 : 4'h6, 2'h0, w[9:8]};
		h2_out[p] <= w[7:0];
		slow_out[p] <= s;
		fast_out[p] <= f;
		@(posedge ref_clk_in);
		frame_out[p] <= 1'b0;
		// bytes are stale outside the frame, so show the inverse
		h1_out[p] <= ~h1_out[p];
		h2_out[p] <= ~h2_out[p];
		if (k == 1) cur[p] = (cur[p] == 10'h30E) ? 10'h000 : cur[p] + 10'h001;
		if (k == 2) cur[p] = (cur[p] == 10'h000) ? 10'h30E : cur[p] - 10'h001;
		if (k == 0 && v <= 10'h30E) cur[p] = v;
	endtask
endmodule
`default_nettype wire

//--- dv/ppj_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ppj_top_tb;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] padr = '0;
	logic [31:0] pwd = '0, prd, rv;
	logic prdy, perr, ev, irq;
	logic [3:0] far = '0, gp, gn, threshold_crossing_alert, frame, slow, fast, tm;
	logic [3:0][7:0] h1, h2;
	logic [3:0] en = 4'b0101;
	logic ce = 1'b1;
	int bad_count = 0, comparisons = 0, pd[4], nd[4], pg[4], ng[4], b1, b2;
	logic [9:0] pv;
	always #5 clk = ~clk;
	ppj_top #(.SEC_CYCLES(50)) u_ppj_top (.ref_clk_in(clk), .sys_rst_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(prdy), .pslverr_out(perr), .frame_in(frame), .h1_in(h1), .h2_in(h2),
		.slow_in(slow), .fast_in(fast), .far_err_in(far), .gen_pos_out(gp), .gen_neg_out(gn),
		.tca_out(threshold_crossing_alert), .irq_out(irq));
	ppj_fram u_ppj_fram (.ref_clk_in(clk), .frame_out(frame), .h1_out(h1), .h2_out(h2),
		.slow_out(slow), .fast_out(fast));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rv = prd;
		ev = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	function automatic int dif(int p);
		int x;
		x = (pg[p] - ng[p]) - (pd[p] - nd[p]);
		return (x < 0) ? -x : x;
	endfunction
	task automatic go(input int p, input int k, input logic [9:0] v, input logic s, input logic f);
		u_ppj_fram.send(p, k, v, s, f);
		@(posedge clk);
		check("gen_pos", gp[p], s & ~f);
		check("gen_neg", gn[p], f & ~s);
		if (en[p] && ce)
		begin
			pd[p] += (k == 1);
			nd[p] += (k == 2);
			pg[p] += s & ~f;
			ng[p] += f & ~s;
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end
	initial
	begin
		void'($urandom(64101));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		apb(0, 12'h00C, 0); check("thr_rst", rv, 32'h0000FFFF);
		apb(0, 12'h100, 0); check("cnt_rst", rv, 0);
		apb(0, 12'h01C, 0); check("unmapped", {ev, rv[30:0]}, 32'h80000000);
		apb(0, 12'h003, 0); check("misaligned", ev, 1);
		apb(1, 12'h010, 32'hF); apb(0, 12'h010, 0); check("stat_ro", rv, 0);
		apb(1, 12'h000, 1); apb(1, 12'h004, 7); apb(1, 12'h008, 2);
		apb(0, 12'h004, 0); check("mon_en", rv, 7);
		pv = 10'($urandom % 783);
		go(0, 0, 10'h30E, 0, 0); go(1, 0, 0, 0, 1); go(2, 0, pv, 1, 0);
		go(3, 0, 10'(783 + $urandom % 241), 0, 0);
		apb(0, 12'h020, 0); check("ptr0", rv, 32'h70E);
		apb(0, 12'h024, 0); check("ptr1", rv, 32'h400);
		apb(0, 12'h028, 0); check("ptr2", rv, {21'h1, pv});
		apb(0, 12'h02C, 0); check("ptr3_bad", rv[10], 0);
		go(0, 1, 0, 0, 0); apb(0, 12'h020, 0); check("ptr0_wrap", rv, 32'h400);
		go(3, 0, 10'($urandom % 783), 0, 0);
		repeat (40) go($urandom % 4, 1 + $urandom % 3, 0, $urandom % 2, $urandom % 2);
		for (int p = 0; p < 4; p++)
			for (int c = 0; c < 5; c++)
			begin
				apb(0, 12'(256 + 32 * p + 4 * c), 0);
				check("just_cnt", rv, (c == 0) ? pd[p] : (c == 1) ? pg[p] : (c == 2) ? nd[p] : (c == 3) ? ng[p] : dif(p));
			end
		repeat (5)
		begin
			@(posedge clk) far <= 4'hF;
			@(posedge clk) far <= 4'h0;
		end
		for (int p = 0; p < 4; p++)
		begin
			apb(0, 12'(284 + 32 * p), 0); check("far_cnt", rv, en[p] ? 5 : 0);
		end
		apb(1, 12'h000, 0);
		ce = 0;
		go(0, 1, 0, 1, 0);
		apb(0, 12'h100, 0); check("cnt_off", rv, 0);
		apb(1, 12'h000, 1);
		ce = 1;
		pd = '{4{0}}; nd = '{4{0}}; pg = '{4{0}}; ng = '{4{0}};
		apb(0, 12'h114, 0); b1 = rv;
		apb(0, 12'h118, 0); b2 = rv;
		repeat (3)
		begin
			go(0, 1, 0, 1, 0); go(0, 2, 0, 1, 0); go(0, 1, 0, 1, 0);
			repeat (60) @(posedge clk);
		end
		apb(0, 12'h114, 0); check("det_sec", (rv - b1 >= 3 && rv - b1 <= 6), 1);
		apb(0, 12'h118, 0); check("gen_sec", (rv - b2 >= 3 && rv - b2 <= 6), 1);
		apb(0, 12'h110, 0); check("diff0", rv, dif(0));
		for (int p = 0; p < 4; p++) tm[p] = en[p] && dif(p) >= 1;
		apb(1, 12'h014, 32'hF); apb(1, 12'h00C, 1);
		repeat (4) @(posedge clk);
		check("tca", threshold_crossing_alert, tm);
		check("irq_on", irq, |tm);
		apb(0, 12'h010, 0); check("status", rv, tm);
		apb(1, 12'h014, 0); repeat (3) @(posedge clk); check("irq_mask", irq, 0);
		apb(1, 12'h014, 32'hF); repeat (3) @(posedge clk); check("irq_unmask", irq, |tm);
		apb(1, 12'h018, 32'hF); apb(0, 12'h010, 0); check("stat_clr", rv, 0);
		repeat (3) @(posedge clk); check("irq_clr", irq, 0);
		conclude();
	end
endmodule
`default_nettype wire
